// *** hdl/iamss_baud.sv ***
`timescale 1ns/100ps
`default_nettype none
module iamss_baud #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk_i,            // system clock
    input wire logic nrst_i,               // async reset, active low
    input wire logic run_i,                // count while high
    input wire logic load_i,               // reload the counter
    input wire logic [WIDTH-1:0] reload_i, // reload value
    output logic tick_o                    // one rollover period elapsed
);

    logic [WIDTH-1:0] cnt_reg;

    // down-counter, reloads on expiry so each tick is one rollover period
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end
        else if (load_i || !run_i)
        begin
            cnt_reg <= reload_i;
            tick_o <= 1'b0;
        end
        else if (cnt_reg == '0)
        begin
            cnt_reg <= reload_i;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg - 1'b1;
            tick_o <= 1'b0;
        end
    end

endmodule : iamss_baud
`default_nettype wire

// *** hdl/iamss_pkg.sv ***
package iamss_pkg;

    // register indices on the plain register port
    localparam logic [3:0] CTRL_ADDR = 4'h0; // control: enables, ack data
    localparam logic [3:0] STAT_ADDR = 4'h1; // status: flags, line levels
    localparam logic [3:0] BAUD_ADDR = 4'h2; // baud reload value
    localparam logic [3:0] TXB_ADDR = 4'h3;  // transmit buffer

    // control field positions
    localparam int CTRL_ACK_SEQ_BIT = 0;
    localparam int CTRL_STOPEN_BIT = 1;
    localparam int CTRL_ACK_VAL_BIT = 2;
    localparam int CTRL_HOLD_BIT = 3;

    // status field positions
    localparam int STAT_COLL_BIT = 0;
    localparam int STAT_STOPDET_BIT = 1;
    localparam int STAT_IRQ_BIT = 2;
    localparam int STAT_SCL_BIT = 3;
    localparam int STAT_SDA_BIT = 4;
    localparam int STAT_BUSY_BIT = 5;

    // reset values
    localparam logic [7:0] BAUD_RESET = 8'h09;
    localparam logic [7:0] TXB_RESET = 8'h00;

    // sequencer states
    typedef enum logic [2:0] {
        IAMSS_IDLE = 3'b000,
        IAMSS_ACK_LOW = 3'b001,
        IAMSS_ACK_WAIT = 3'b010,
        IAMSS_ACK_HIGH = 3'b011,
        IAMSS_STP_SDA = 3'b100,
        IAMSS_STP_LOW = 3'b101,
        IAMSS_STP_SCL = 3'b110,
        IAMSS_STP_DONE = 3'b111
    } iamss_state_t;

    // open-drain pin bundle, toward the pads
    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } iamss_pins_t;

endpackage : iamss_pkg

// *** hdl/iamss_top.sv ***
// Operation
// - setting the ack enable pulls scl low and puts the ack data bit on sda.
// - after the ack bit is presented, one rollover period passes, then scl is released.
// - once scl is seen high, one more rollover period passes and scl is pulled low again.
// - at the end of the ack sequence the enable clears, the baud counter stops, idle returns.
// - a transmit buffer write during an ack sequence sets write collision and is dropped.
// - after a byte ends scl stays held low past the ninth clock's falling edge.
// - setting the stop enable first drives sda low.
// - when sda is seen low in a stop sequence the baud counter reloads and counts to zero.
// - at baud expiry scl is released, and sda is released one rollover period later.
// - stop detected is set when sda is seen high while scl is high.
// - one rollover period after stop detection the stop enable clears and the irq flag sets.
// - a transmit buffer write during a stop sequence sets write collision and is dropped.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module iamss_top #(
    parameter int BAUD_W = 8
) (
    input wire logic sys_clk_i,     // 200 MHz system clock
    input wire logic nrst_i,        // async reset, active low
    input wire logic [3:0] addr_i,  // register index
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i,          // write strobe
    input wire logic rd_i,          // read strobe
    output logic [7:0] rdata_o,     // read data, cycle after rd_i
    input wire logic scl_i,         // scl pad level
    output logic scl_o,             // scl drive value, always low
    output logic scl_oe_o,          // scl pulled low while high
    input wire logic sda_i,         // sda pad level
    output logic sda_o,             // sda drive value, always low
    output logic sda_oe_o,          // sda pulled low while high
    output logic [7:0] txbuf_o      // transmit buffer contents
);

    iamss_pkg::iamss_state_t state_reg;
    iamss_pkg::iamss_pins_t pins_reg;
    logic ack_seq_enable_reg;
    logic stop_seq_enable_reg;
    logic ack_data_value_reg;
    logic hold_reg;
    logic write_collision_flag_reg;
    logic stop_det_reg;
    logic serial_irq_flag_reg;
    logic [BAUD_W-1:0] baud_reg;
    logic [7:0] transmit_buffer_reg;
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_lvl_reg;
    logic sda_lvl_reg;
    logic busy;
    logic brg_run;
    logic brg_load;
    logic brg_tick;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_txb;

    assign busy = (state_reg != iamss_pkg::IAMSS_IDLE);
    assign wr_ctrl = wr_i && (addr_i == iamss_pkg::CTRL_ADDR);
    assign wr_stat = wr_i && (addr_i == iamss_pkg::STAT_ADDR);
    assign wr_txb = wr_i && (addr_i == iamss_pkg::TXB_ADDR);

    // three-stage pad synchronisers, filtered level when stages two and three agree
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_lvl_reg <= 1'b1;
            sda_lvl_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
            if (scl_sync_reg[1] == scl_sync_reg[2])
                scl_lvl_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2])
                sda_lvl_reg <= sda_sync_reg[2];
        end
    end

    // baud counter runs only inside a sequence, and is held reloaded in the waits for scl high and sda low
    assign brg_run = busy && (state_reg != iamss_pkg::IAMSS_ACK_WAIT)
        && (state_reg != iamss_pkg::IAMSS_STP_SDA);
    // reload once sda is seen low, and hold reloaded until stop is detected so the
    // irq step comes a full rollover after detection
    assign brg_load = ((state_reg == iamss_pkg::IAMSS_STP_SDA) && !sda_lvl_reg)
        || ((state_reg == iamss_pkg::IAMSS_STP_DONE) && !stop_det_reg);

    iamss_baud #(
        .WIDTH(BAUD_W)
    ) u_baud (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .run_i(brg_run),
        .load_i(brg_load),
        .reload_i(baud_reg),
        .tick_o(brg_tick)
    );

    // sequencer: walks the ack and stop waveforms one rollover period per step, except the waits for scl high, sda low and stop detection
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_reg <= iamss_pkg::IAMSS_IDLE;
        else
        begin
            case (state_reg)
                iamss_pkg::IAMSS_IDLE:
                begin
                    if (wr_ctrl && wdata_i[iamss_pkg::CTRL_ACK_SEQ_BIT])
                        state_reg <= iamss_pkg::IAMSS_ACK_LOW;
                    else if (wr_ctrl && wdata_i[iamss_pkg::CTRL_STOPEN_BIT])
                        state_reg <= iamss_pkg::IAMSS_STP_SDA;
                end
                iamss_pkg::IAMSS_ACK_LOW:
                    if (brg_tick)
                        state_reg <= iamss_pkg::IAMSS_ACK_WAIT;
                iamss_pkg::IAMSS_ACK_WAIT:
                    if (scl_lvl_reg)
                        state_reg <= iamss_pkg::IAMSS_ACK_HIGH;
                iamss_pkg::IAMSS_ACK_HIGH:
                    if (brg_tick)
                        state_reg <= iamss_pkg::IAMSS_IDLE;
                iamss_pkg::IAMSS_STP_SDA:
                    if (!sda_lvl_reg)
                        state_reg <= iamss_pkg::IAMSS_STP_LOW;
                iamss_pkg::IAMSS_STP_LOW:
                    if (brg_tick)
                        state_reg <= iamss_pkg::IAMSS_STP_SCL;
                iamss_pkg::IAMSS_STP_SCL:
                    if (brg_tick)
                        state_reg <= iamss_pkg::IAMSS_STP_DONE;
                iamss_pkg::IAMSS_STP_DONE:
                    if (stop_det_reg && brg_tick)
                        state_reg <= iamss_pkg::IAMSS_IDLE;
                default:
                    state_reg <= iamss_pkg::IAMSS_IDLE;
            endcase
        end
    end

    // open-drain drive: enable means pull low, release lets the pull-up win
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pins_reg <= '0;
        else
        begin
            case (state_reg)
                iamss_pkg::IAMSS_IDLE:
                begin
                    if (wr_ctrl && wdata_i[iamss_pkg::CTRL_ACK_SEQ_BIT])
                    begin
                        pins_reg.scl_oe <= 1'b1;
                        pins_reg.sda_oe <= !wdata_i[iamss_pkg::CTRL_ACK_VAL_BIT];
                    end
                    else if (wr_ctrl && wdata_i[iamss_pkg::CTRL_STOPEN_BIT])
                    begin
                        pins_reg.scl_oe <= 1'b1;
                        pins_reg.sda_oe <= 1'b1;
                    end
                    else
                        pins_reg.scl_oe <= hold_reg;
                end
                iamss_pkg::IAMSS_ACK_LOW:
                    if (brg_tick)
                        pins_reg.scl_oe <= 1'b0;
                iamss_pkg::IAMSS_ACK_HIGH:
                    if (brg_tick)
                        pins_reg.scl_oe <= 1'b1;
                iamss_pkg::IAMSS_STP_LOW:
                    if (brg_tick)
                        pins_reg.scl_oe <= 1'b0;
                iamss_pkg::IAMSS_STP_SCL:
                    if (brg_tick)
                        pins_reg.sda_oe <= 1'b0;
                default:
                    pins_reg <= pins_reg;
            endcase
        end
    end

    // control bits: software sets; hardware clears the enable on completion, sets hold after ack, clears it after stop
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_seq_enable_reg <= 1'b0;
            stop_seq_enable_reg <= 1'b0;
            ack_data_value_reg <= 1'b0;
            hold_reg <= 1'b1;
        end
        else
        begin
            if (wr_ctrl && !busy)
            begin
                ack_data_value_reg <= wdata_i[iamss_pkg::CTRL_ACK_VAL_BIT];
                hold_reg <= wdata_i[iamss_pkg::CTRL_HOLD_BIT];
                ack_seq_enable_reg <= wdata_i[iamss_pkg::CTRL_ACK_SEQ_BIT];
                stop_seq_enable_reg <= wdata_i[iamss_pkg::CTRL_STOPEN_BIT]
                    && !wdata_i[iamss_pkg::CTRL_ACK_SEQ_BIT];
            end
            else
            begin
                if (state_reg == iamss_pkg::IAMSS_ACK_HIGH && brg_tick)
                begin
                    ack_seq_enable_reg <= 1'b0;
                    hold_reg <= 1'b1;
                end
                if (state_reg == iamss_pkg::IAMSS_STP_DONE && stop_det_reg && brg_tick)
                begin
                    stop_seq_enable_reg <= 1'b0;
                    hold_reg <= 1'b0;
                end
            end
        end
    end

    // status flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            write_collision_flag_reg <= 1'b0;
            stop_det_reg <= 1'b0;
            serial_irq_flag_reg <= 1'b0;
        end
        else
        begin
            if (wr_txb && busy)
                write_collision_flag_reg <= 1'b1;
            else if (wr_stat && !wdata_i[iamss_pkg::STAT_COLL_BIT])
                write_collision_flag_reg <= 1'b0;
            if (state_reg == iamss_pkg::IAMSS_STP_DONE && sda_lvl_reg && scl_lvl_reg)
                stop_det_reg <= 1'b1;
            else if (wr_ctrl && wdata_i[iamss_pkg::CTRL_ACK_SEQ_BIT])
                stop_det_reg <= 1'b0;
            else if (wr_stat && !wdata_i[iamss_pkg::STAT_STOPDET_BIT])
                stop_det_reg <= 1'b0;
            if (state_reg == iamss_pkg::IAMSS_STP_DONE && stop_det_reg && brg_tick)
                serial_irq_flag_reg <= 1'b1;
            else if (wr_stat && !wdata_i[iamss_pkg::STAT_IRQ_BIT])
                serial_irq_flag_reg <= 1'b0;
        end
    end

    // baud reload and transmit buffer; buffer writes during a sequence are dropped
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            baud_reg <= BAUD_W'(iamss_pkg::BAUD_RESET);
            transmit_buffer_reg <= iamss_pkg::TXB_RESET;
        end
        else
        begin
            if (wr_i && addr_i == iamss_pkg::BAUD_ADDR)
                baud_reg <= BAUD_W'(wdata_i);
            if (wr_txb && !busy)
                transmit_buffer_reg <= wdata_i;
        end
    end

    // read port, data stands in the cycle after the strobe only
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            case (addr_i)
                iamss_pkg::CTRL_ADDR:
                    rdata_o <= {4'h0, hold_reg, ack_data_value_reg,
                        stop_seq_enable_reg, ack_seq_enable_reg};
                iamss_pkg::STAT_ADDR:
                    rdata_o <= {2'b00, busy, sda_lvl_reg, scl_lvl_reg,
                        serial_irq_flag_reg, stop_det_reg, write_collision_flag_reg};
                iamss_pkg::BAUD_ADDR:
                    rdata_o <= 8'(baud_reg);
                iamss_pkg::TXB_ADDR:
                    rdata_o <= transmit_buffer_reg;
                default:
                    rdata_o <= 8'h00;
            endcase
        end
        else
            rdata_o <= 8'h00;
    end

    // pad outputs, all from flip-flops; drive value is constant low
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            txbuf_o <= 8'h00;
        end
        else
        begin
            scl_oe_o <= pins_reg.scl_oe;
            sda_oe_o <= pins_reg.sda_oe;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            txbuf_o <= transmit_buffer_reg;
        end
    end

endmodule : iamss_top
`default_nettype wire

// *** testbench/iamss_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module iamss_properties #(
    parameter int BAUD_W = 8
) (
    input wire logic sys_clk_i,      // system clock
    input wire logic nrst_i,         // async reset, active low
    input wire logic [3:0] addr_i,   // register index
    input wire logic [7:0] wdata_i,  // write data
    input wire logic wr_i,           // write strobe
    input wire logic scl_i,          // scl pad level
    input wire logic scl_o,          // scl drive value
    input wire logic scl_oe_o,       // scl pulled low
    input wire logic sda_o,          // sda drive value
    input wire logic sda_oe_o,       // sda pulled low
    input wire logic [7:0] txbuf_o   // buffer copy
);
    logic tx_wr_q;
    logic tx_wr_qq;
    logic ack_v_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // remembers a buffer write for two cycles
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tx_wr_q <= 1'b0;
            tx_wr_qq <= 1'b0;
            ack_v_q <= 1'b0;
        end
        else
        begin
            tx_wr_q <= wr_i && addr_i == iamss_pkg::TXB_ADDR;
            tx_wr_qq <= tx_wr_q;
            if (wr_i && addr_i == iamss_pkg::CTRL_ADDR && wdata_i[0])
                ack_v_q <= wdata_i[2]; // ack data value of the last ack start
        end
    end

    // control writes that start each sequence
    sequence ack_wr_s;
        wr_i && addr_i == iamss_pkg::CTRL_ADDR && wdata_i[0] && !wdata_i[1];
    endsequence
    sequence stop_wr_s;
        wr_i && addr_i == iamss_pkg::CTRL_ADDR && wdata_i[1] && !wdata_i[0];
    endsequence

    // ack bit follows the ack data value
    property ack_pins_p;
        ack_wr_s |-> ##[2:4] (scl_oe_o && sda_oe_o == !ack_v_q);
    endproperty

    a_lines_low_only: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("a line is driven high");
    a_ack_bit_shown: assert property (ack_pins_p)
        else $error("ack bit not presented");
    a_ack_scl_release: assert property (
        ack_wr_s |-> ##4 scl_oe_o [*6] ##[1:40] !scl_oe_o)
        else $error("scl not released after one rollover");
    a_scl_low_after_high: assert property ($rose(scl_oe_o) |-> $past(scl_i, 8))
        else $error("scl pulled low before it was seen high");
    a_scl_high_span: assert property ($fell(scl_oe_o) |-> ##1 !scl_oe_o [*8])
        else $error("scl released for less than a rollover");
    a_stop_sda_first: assert property (stop_wr_s |-> ##[2:4] sda_oe_o)
        else $error("sda not pulled low at stop start");
    a_stop_release_order: assert property (
        stop_wr_s |-> ##[2:60] $fell(scl_oe_o) ##[9:11] $fell(sda_oe_o))
        else $error("stop release order or spacing wrong");
    a_txbuf_write_only: assert property (
        !$stable(txbuf_o) |-> tx_wr_q || tx_wr_qq)
        else $error("buffer changed without a write");
endmodule : iamss_properties

bind iamss_top iamss_properties #(.BAUD_W(BAUD_W)) i_iamss_properties (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .txbuf_o(txbuf_o)
);
`default_nettype wire

// *** testbench/iamss_slave_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module iamss_slave_model (
    input wire logic sys_clk_i,       // system clock
    input wire logic nrst_i,          // async reset, active low
    input wire logic scl_oe_i,        // master pulls scl low
    input wire logic sda_oe_i,        // master pulls sda low
    input wire logic [7:0] stretch_i, // cycles to stretch scl
    output logic scl_o,               // wired scl level
    output logic sda_o                // wired sda level
);
    logic scl_oe_q;
    logic [7:0] hold_cnt;

    // stretches scl low for a while after the master lets it go
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            scl_oe_q <= 1'b0;
            hold_cnt <= 8'h00;
        end
        else
        begin
            scl_oe_q <= scl_oe_i;
            if (scl_oe_q && !scl_oe_i)
                hold_cnt <= stretch_i;
            else if (hold_cnt != 8'h00)
                hold_cnt <= hold_cnt - 8'h01;
        end
    end

    // open-drain lines with pull-ups: low while any party pulls
    assign scl_o = !(scl_oe_i || scl_oe_q || hold_cnt != 8'h00);
    assign sda_o = !sda_oe_i;
endmodule : iamss_slave_model
`default_nettype wire

// *** testbench/tb_iamss_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_iamss_top;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic scl_i;
    logic scl_o;
    logic scl_oe_o;
    logic sda_i;
    logic sda_o;
    logic sda_oe_o;
    logic [7:0] txbuf_o;
    logic [7:0] stretch = 8'h00;
    logic [7:0] d;
    int bad_count = 0;
    int n_compared = 0;

    // 200 MHz clock
    always #2.5 sys_clk_i = ~sys_clk_i;

    // block and the slave on the far side of the lines
    iamss_top i_iamss_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .txbuf_o(txbuf_o));
    iamss_slave_model i_iamss_slave_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .stretch_i(stretch), .scl_o(scl_i),
        .sda_o(sda_i));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    // polls a control bit until the sequence clears it
    task automatic wait_clear(input int b);
        int n;
        n = 0;
        rd(iamss_pkg::CTRL_ADDR);
        while (d[b] !== 1'b0 && n < 200)
        begin
            rd(iamss_pkg::CTRL_ADDR);
            n++;
        end
        check({7'h00, d[b]}, 8'h00);
    endtask : wait_clear

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // main sequence: reset values, ack and nack, stop
    initial
    begin
        repeat (20) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        rd(iamss_pkg::CTRL_ADDR);
        check(d, 8'h08);
        rd(iamss_pkg::BAUD_ADDR);
        check(d, iamss_pkg::BAUD_RESET);
        wr(iamss_pkg::BAUD_ADDR, 8'h5A);
        rd(iamss_pkg::BAUD_ADDR);
        check(d, 8'h5A);
        wr(iamss_pkg::BAUD_ADDR, iamss_pkg::BAUD_RESET);
        rd(4'hF);
        check(d, 8'h00);
        check({7'h00, scl_oe_o}, 8'h01);
        wr(iamss_pkg::TXB_ADDR, 8'hA5);
        rd(iamss_pkg::TXB_ADDR);
        check(d, 8'hA5);
        $display("reset and idle test done");
        for (int k = 0; k < 2; k++)
        begin
            stretch <= k[0] ? 8'h05 : 8'h00;
            wr(iamss_pkg::CTRL_ADDR, {5'h00, k[0], 2'b01});
            tick(3);
            check({6'h00, scl_oe_o, sda_oe_o}, {6'h00, 1'b1, !k[0]});
            wr(iamss_pkg::TXB_ADDR, 8'h3C);
            wait_clear(iamss_pkg::CTRL_ACK_SEQ_BIT);
            tick(3);
            check({7'h00, scl_oe_o}, 8'h01);
            rd(iamss_pkg::STAT_ADDR);
            check(d & 8'h27, 8'h01);
            check(txbuf_o, 8'hA5);
            wr(iamss_pkg::STAT_ADDR, 8'h00);
            rd(iamss_pkg::STAT_ADDR);
            check(d & 8'h07, 8'h00);
            $display("ack test %0d done", k);
        end
        stretch <= 8'h00;
        wr(iamss_pkg::CTRL_ADDR, 8'h02);
        tick(3);
        check({7'h00, sda_oe_o}, 8'h01);
        wr(iamss_pkg::TXB_ADDR, 8'h77);
        wait_clear(iamss_pkg::CTRL_STOPEN_BIT);
        rd(iamss_pkg::STAT_ADDR);
        check(d, 8'h1F);
        check({6'h00, scl_oe_o, sda_oe_o}, 8'h00);
        check(txbuf_o, 8'hA5);
        $display("stop test done");
        results();
    end

    // watchdog against a hung sequence
    initial
    begin
        #50000;
        bad_count++;
        results();
    end
endmodule : tb_iamss_top
`default_nettype wire
